// ### include/ldisp_pkg.sv
package ldisp_pkg;
    // Slave address: fixed upper bits, low two bits from the strap
    localparam logic [4:0] ADDR_UPPER = 5'h0C;
    // Register sub-addresses
    localparam logic [7:0] CMD_OFF = 8'h00;
    localparam logic [7:0] DIM_OFF = 8'h01;
    localparam logic [7:0] AUX_OFF = 8'h02;
    localparam logic [7:0] STAT_OFF = 8'h03;
    // Values after reset
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [7:0] DIM_RST = 8'h00;
    localparam logic [7:0] AUX_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    // Field positions
    localparam int PWR_BIT = 7;
    localparam int FLASH_TRIGGER_ENABLE_BIT = 6;
    localparam int FLASH_TOP_BIT = 3;
    localparam int STAT_TIMEOUT_BIT = 0;
    // Bit counts of a byte
    localparam logic [3:0] BITS_RX = 4'h8;
    localparam logic [3:0] BITS_TX_LAST = 4'h7;
    // Serial engine states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_MACK
    } ldisp_state_t;
    // Meaning of the byte being received
    typedef enum logic [1:0] {
        K_ADDR,
        K_REG,
        K_DATA
    } ldisp_kind_t;
endpackage

// ### hdl/ldisp_sync.sv
`timescale 1ns/10ps
module ldisp_sync #(
    parameter int W = 1
) (
    input wire logic clock, // System clock
    input wire logic resetn, // Async reset, active low
    input wire logic [W-1:0] async_in, // Levels from outside the domain
    output logic [W-1:0] sync_out // Two-stage synchronised levels
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } ldisp_sync_t;

    ldisp_sync_t st;
    ldisp_sync_t next_st;

    // First stage feeds only the second
    always_comb begin
        next_st.meta = async_in;
        next_st.sync = st.meta;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.sync;
endmodule

// ### hdl/ldisp_port.sv
`timescale 1ns/10ps
// Contract
// - Flash activation is trigger pin AND trigger-enable bit.
// - Attention is open-drain active low, set when status gains news.
// - Reading the status register releases attention.
// - Address is 01100 plus two strap-selected low bits.
// - Top flash level bit plus mask pin caps current at 200 mA.
// - SDA changes only while SCL low; high-phase change is control.
// - Idle lines high; start is SDA fall, stop SDA rise, SCL high.
// - Bytes are eight bits, MSB first, then an acknowledge bit.
// - Device pulls SDA low through ack pulse after each received byte.
// - Last address bit: 1 read, 0 write.
// - Write: address, register, data, each acknowledged, then stop.
// - Register pointer increments after every read or write.
// - Read: write register address, repeated start, read address, data.
// - Master ack fetches the next register; no ack ends the read.
// - Timer expiry clears trigger enable and asserts attention.
// - Flash activation only while power-enable bit set.
module ldisp_port (
    input wire logic clock, // 100 MHz system clock
    input wire logic resetn, // Async reset, active low
    input wire logic scl_in, // Bus clock pin level
    input wire logic sda_in, // Bus data pin level
    output logic sda_out, // Data drive value, always low
    output logic sda_oe, // Data pull-down enable
    input wire logic [1:0] addr_strap, // Address strap code
    input wire logic flash_trigger_pin, // Hard trigger pin
    input wire logic transmit_mask_pin, // Transmit mask pin
    input wire logic flash_timer_done, // Flash counter expired, pulse
    input wire logic [7:0] status_event, // Status news, pulses
    output logic attention_out, // Attention drive value, always low
    output logic attention_oe, // Attention pull-down enable
    output logic flash_on, // Internal flash activation
    output logic current_cap, // Force 200 mA level
    output logic [7:0] cmd_reg, // Command register
    output logic [7:0] dim_reg, // Dimming register
    output logic [7:0] aux_reg // Auxiliary register
);
    typedef struct packed {
        ldisp_pkg::ldisp_state_t state;
        ldisp_pkg::ldisp_kind_t kind;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic rw;
        logic mack;
        logic rd_stat;
        logic sda_oe;
        logic scl_q;
        logic sda_q;
        logic [1:0] strap;
        logic strap_done;
        logic [1:0] strap_wait;
        logic [7:0] cmd;
        logic [7:0] dim;
        logic [7:0] aux;
        logic [7:0] stat;
    } ldisp_core_t;

    ldisp_core_t st;
    ldisp_core_t next_st;
    logic [5:0] pins_s;
    logic scl_s, sda_s, flash_trigger_pin_s, mask_s;
    logic [1:0] strap_s;
    logic scl_rise, scl_fall, start_c, stop_c, stat_clr;
    logic power_enable_bit, flash_trigger_enable, flash_level_top_bit;
    logic [7:0] rd_data;

    // All pin inputs cross into the clock domain here
    ldisp_sync #(.W(6)) u_sync (
        .clock(clock),
        .resetn(resetn),
        .async_in({scl_in, sda_in, flash_trigger_pin, transmit_mask_pin, addr_strap}),
        .sync_out(pins_s)
    );

    assign {scl_s, sda_s, flash_trigger_pin_s, mask_s, strap_s} = pins_s;

    // Bus edges and conditions from synchronised levels
    assign scl_rise = scl_s & ~st.scl_q;
    assign scl_fall = ~scl_s & st.scl_q;
    assign start_c = st.scl_q & scl_s & st.sda_q & ~sda_s;
    assign stop_c = st.scl_q & scl_s & ~st.sda_q & sda_s;

    assign power_enable_bit = st.cmd[ldisp_pkg::PWR_BIT];
    assign flash_trigger_enable = st.cmd[ldisp_pkg::FLASH_TRIGGER_ENABLE_BIT];
    assign flash_level_top_bit = st.dim[ldisp_pkg::FLASH_TOP_BIT];

    // Read mux; unmapped sub-addresses read as zero
    always_comb begin
        unique case (st.ptr)
            ldisp_pkg::CMD_OFF: rd_data = st.cmd;
            ldisp_pkg::DIM_OFF: rd_data = st.dim;
            ldisp_pkg::AUX_OFF: rd_data = st.aux;
            ldisp_pkg::STAT_OFF: rd_data = st.stat;
            default: rd_data = 8'h00;
        endcase
    end

    // Serial engine, register file and status in one next-state step
    always_comb begin
        next_st = st;
        stat_clr = 1'b0;
        next_st.scl_q = scl_s;
        next_st.sda_q = sda_s;
        // Strap caught once the synchroniser has refilled after release;
        // earlier its output still holds the reset zeros
        next_st.strap_wait = {st.strap_wait[0], 1'b1};
        if (st.strap_wait[1] && !st.strap_done) begin
            next_st.strap = strap_s;
            next_st.strap_done = 1'b1;
        end
        if (start_c) begin
            // A repeated start restarts address reception too
            next_st.state = ldisp_pkg::ST_RX;
            next_st.kind = ldisp_pkg::K_ADDR;
            next_st.cnt = 4'h0;
            next_st.sda_oe = 1'b0;
        end else if (stop_c) begin
            next_st.state = ldisp_pkg::ST_IDLE;
            next_st.sda_oe = 1'b0;
        end else begin
            unique case (st.state)
                ldisp_pkg::ST_IDLE: begin
                    next_st.sda_oe = 1'b0;
                end
                ldisp_pkg::ST_RX: begin
                    if (scl_rise) begin
                        next_st.shift = {st.shift[6:0], sda_s};
                        next_st.cnt = st.cnt + 4'h1;
                    end
                    if (scl_fall && st.cnt == ldisp_pkg::BITS_RX) begin
                        next_st.state = ldisp_pkg::ST_ACK;
                        next_st.sda_oe = 1'b1;
                        unique case (st.kind)
                            ldisp_pkg::K_ADDR: begin
                                next_st.rw = st.shift[0];
                                if (st.shift[7:1] != {ldisp_pkg::ADDR_UPPER, st.strap}) begin
                                    next_st.state = ldisp_pkg::ST_IDLE;
                                    next_st.sda_oe = 1'b0;
                                end
                            end
                            ldisp_pkg::K_REG: next_st.ptr = st.shift;
                            ldisp_pkg::K_DATA: begin
                                // Status is read only; writes there are dropped
                                unique case (st.ptr)
                                    ldisp_pkg::CMD_OFF: next_st.cmd = st.shift;
                                    ldisp_pkg::DIM_OFF: next_st.dim = st.shift;
                                    ldisp_pkg::AUX_OFF: next_st.aux = st.shift;
                                    default: next_st.cmd = st.cmd;
                                endcase
                                next_st.ptr = st.ptr + 8'h01;
                            end
                            default: next_st.state = ldisp_pkg::ST_IDLE;
                        endcase
                    end
                end
                ldisp_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        next_st.cnt = 4'h0;
                        if (st.kind == ldisp_pkg::K_ADDR && st.rw) begin
                            // Load first read byte at the ack's falling edge
                            next_st.state = ldisp_pkg::ST_TX;
                            next_st.shift = rd_data;
                            next_st.sda_oe = ~rd_data[7];
                            next_st.rd_stat = (st.ptr == ldisp_pkg::STAT_OFF);
                            next_st.ptr = st.ptr + 8'h01;
                        end else begin
                            next_st.state = ldisp_pkg::ST_RX;
                            next_st.sda_oe = 1'b0;
                            next_st.kind = (st.kind == ldisp_pkg::K_ADDR) ?
                                ldisp_pkg::K_REG : ldisp_pkg::K_DATA;
                        end
                    end
                end
                ldisp_pkg::ST_TX: begin
                    // Drive changes only after SCL has fallen
                    if (scl_fall) begin
                        if (st.cnt == ldisp_pkg::BITS_TX_LAST) begin
                            next_st.state = ldisp_pkg::ST_MACK;
                            next_st.sda_oe = 1'b0;
                            stat_clr = st.rd_stat;
                        end else begin
                            next_st.shift = {st.shift[6:0], 1'b0};
                            next_st.sda_oe = ~st.shift[6];
                            next_st.cnt = st.cnt + 4'h1;
                        end
                    end
                end
                ldisp_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        next_st.mack = ~sda_s;
                    end
                    if (scl_fall) begin
                        if (st.mack) begin
                            next_st.state = ldisp_pkg::ST_TX;
                            next_st.cnt = 4'h0;
                            next_st.shift = rd_data;
                            next_st.sda_oe = ~rd_data[7];
                            next_st.rd_stat = (st.ptr == ldisp_pkg::STAT_OFF);
                            next_st.ptr = st.ptr + 8'h01;
                        end else begin
                            next_st.state = ldisp_pkg::ST_IDLE;
                        end
                    end
                end
                default: next_st.state = ldisp_pkg::ST_IDLE;
            endcase
        end
        // Timer expiry beats a same-cycle bus write to the enable bit
        if (flash_timer_done) begin
            next_st.cmd[ldisp_pkg::FLASH_TRIGGER_ENABLE_BIT] = 1'b0;
        end
        // Sticky status; a new event wins over the read clear
        if (stat_clr) begin
            next_st.stat = ldisp_pkg::STAT_RST;
        end
        next_st.stat = next_st.stat | status_event;
        next_st.stat[ldisp_pkg::STAT_TIMEOUT_BIT] =
            next_st.stat[ldisp_pkg::STAT_TIMEOUT_BIT] | flash_timer_done;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
            st.cmd <= ldisp_pkg::CMD_RST;
            st.dim <= ldisp_pkg::DIM_RST;
            st.aux <= ldisp_pkg::AUX_RST;
            st.stat <= ldisp_pkg::STAT_RST;
            st.scl_q <= 1'b1;
            st.sda_q <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Open-drain pins only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = st.sda_oe;
    assign attention_out = 1'b0;
    assign attention_oe = |st.stat;
    assign flash_on = flash_trigger_pin_s & flash_trigger_enable & power_enable_bit;
    assign current_cap = flash_level_top_bit & mask_s;
    assign cmd_reg = st.cmd;
    assign dim_reg = st.dim;
    assign aux_reg = st.aux;

    // Checks on the pin logic and the serial engine
    a_flash_gate: assert property (@(posedge clock) disable iff (!resetn)
        !flash_trigger_pin_s |-> !flash_on) else $error("flash active without trigger pin");
    a_flash_power: assert property (@(posedge clock) disable iff (!resetn)
        flash_on |-> power_enable_bit) else $error("flash active without power");
    a_timeout_path: assert property (@(posedge clock) disable iff (!resetn)
        flash_timer_done |=> !flash_trigger_enable && attention_oe)
        else $error("timer expiry did not clear enable and raise attention");
    a_attn_hold: assert property (@(posedge clock) disable iff (!resetn)
        attention_oe && !stat_clr |=> attention_oe) else $error("attention dropped alone");
    a_stat_release: assert property (@(posedge clock) disable iff (!resetn)
        stat_clr && status_event == 8'h00 && !flash_timer_done |=> !attention_oe)
        else $error("status read did not release attention");
    a_mask_cap: assert property (@(posedge clock) disable iff (!resetn)
        current_cap == (flash_level_top_bit && mask_s)) else $error("current cap wrong");
    a_ack_drive: assert property (@(posedge clock) disable iff (!resetn)
        st.state == ldisp_pkg::ST_ACK |-> sda_oe) else $error("ack not driven");
    a_idle_release: assert property (@(posedge clock) disable iff (!resetn)
        st.state == ldisp_pkg::ST_IDLE ##1 st.state == ldisp_pkg::ST_IDLE |-> !sda_oe)
        else $error("SDA driven while not addressed");
    a_sda_low_change: assert property (@(posedge clock) disable iff (!resetn)
        $rose(sda_oe) |-> !$past(scl_s)) else $error("SDA pulled while SCL high");
endmodule

// ### verification/ldisp_host.sv
`timescale 1ns/10ps
module ldisp_host (
    output logic scl, // Bus clock drive
    output logic sda_pull, // High pulls data low
    input wire logic sda // Wired data level
);
    // Quarter of the 125 ns bus period; data moves mid-low, well clear of the sync lag
    localparam real Q = 31.25;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Start or repeated start, ends with clock low
    task automatic start();
        #Q sda_pull = 1'b0;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b1;
        #Q scl = 1'b0;
    endtask
    // Stop from clock low, leaves both lines idle high
    task automatic stop();
        #Q sda_pull = 1'b1;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b0;
        #Q;
    endtask
    // One clock pulse; data held over the high phase, sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        #Q sda_pull = ~b;
        #Q scl = 1'b1;
        #Q s = sda;
        #Q scl = 1'b0;
    endtask
    // Byte out MSB first, then release for the acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, ack);
    endtask
    // Byte in; master acknowledge asks for the next register
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(~mack, s);
    endtask
endmodule

// ### verification/tb_led_driver_i2c_slave_port.sv
`timescale 1ns/10ps
module tb_led_driver_i2c_slave_port;
    logic clock, resetn, scl, sda_pull, sda_oe, sda_out, flash_trigger_pin, transmit_mask_pin;
    logic flash_timer_done, attention_out, attention_oe, flash_on, current_cap;
    logic [1:0] addr_strap;
    logic [7:0] status_event, cmd_reg, dim_reg, aux_reg;
    logic [7:0] rd[$];
    logic [6:0] dev;
    int n_fail, tests_run;
    // Open-drain data line with pull-up
    wire logic sda = ~(sda_pull | sda_oe);
    ldisp_port i_dut (.clock(clock), .resetn(resetn), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap),
        .flash_trigger_pin(flash_trigger_pin), .transmit_mask_pin(transmit_mask_pin),
        .flash_timer_done(flash_timer_done), .status_event(status_event),
        .attention_out(attention_out), .attention_oe(attention_oe), .flash_on(flash_on),
        .current_cap(current_cap), .cmd_reg(cmd_reg), .dim_reg(dim_reg), .aux_reg(aux_reg));
    ldisp_host i_host (.scl(scl), .sda_pull(sda_pull), .sda(sda));
    initial clock = 1'b0;
    always #5 clock = ~clock;
    // Compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        if (n_fail == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Strap applied well before release so its synced value is captured
    task automatic do_reset(input logic [1:0] strap);
        @(posedge clock);
        #1 resetn = 1'b0;
        addr_strap = strap;
        repeat (5) @(posedge clock);
        #1 resetn = 1'b1;
        repeat (6) @(posedge clock);
    endtask
    // Register write burst; an unanswered address is abandoned with a stop
    task automatic wr(input logic [6:0] a, input logic [7:0] sub, input logic [7:0] d[$],
        input logic exp_ack);
        logic k;
        i_host.start();
        i_host.wbyte({a, 1'b0}, k);
        check("address ack", {7'h00, k}, {7'h00, ~exp_ack});
        if (exp_ack) begin
            i_host.wbyte(sub, k);
            check("sub ack", {7'h00, k}, 8'h00);
            foreach (d[i]) begin
                i_host.wbyte(d[i], k);
                check("data ack", {7'h00, k}, 8'h00);
            end
        end
        i_host.stop();
    endtask
    // Register read burst through a repeated start
    task automatic rdn(input logic [7:0] sub, input int n);
        logic k;
        logic [7:0] b;
        rd = {};
        i_host.start();
        i_host.wbyte({dev, 1'b0}, k);
        i_host.wbyte(sub, k);
        i_host.start();
        i_host.wbyte({dev, 1'b1}, k);
        check("read ack", {7'h00, k}, 8'h00);
        for (int i = 0; i < n; i++) begin
            i_host.rbyte(i < n - 1, b);
            rd.push_back(b);
        end
        i_host.stop();
    endtask
    // Hang guard
    initial begin
        repeat (40000) @(posedge clock);
        n_fail++;
        results();
    end
    initial begin
        {resetn, flash_trigger_pin, transmit_mask_pin, flash_timer_done} = 4'h0;
        status_event = 8'h00;
        addr_strap = 2'h0;
        // Each strap code answers its own address and not the neighbour differing in bit 0
        for (int s = 0; s < 4; s++) begin
            do_reset(s[1:0]);
            dev = {ldisp_pkg::ADDR_UPPER, s[1:0]};
            check("cmd after reset", cmd_reg, 8'h00);
            wr({ldisp_pkg::ADDR_UPPER, s[1:0] ^ 2'h1}, 8'h02, '{8'h55}, 1'b0);
            wr(dev, 8'h02, '{s[7:0] + 8'h10}, 1'b1);
            check("aux", aux_reg, s[7:0] + 8'h10);
        end
        // Burst write steps the pointer across three registers
        wr(dev, 8'h00, '{8'hC0, 8'h08, 8'hA5}, 1'b1);
        check("cmd", cmd_reg, 8'hC0);
        check("dim", dim_reg, 8'h08);
        check("aux", aux_reg, 8'hA5);
        // All pin combinations against enable and top level bit
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            #1 flash_trigger_pin = k[0];
            transmit_mask_pin = k[1];
            repeat (4) @(posedge clock);
            #1 check("flash_on", {7'h00, flash_on}, {7'h00, k[0]});
            check("current_cap", {7'h00, current_cap}, {7'h00, k[1]});
        end
        // Power off blocks flash; low level ignores the mask
        wr(dev, 8'h00, '{8'h40, 8'h07}, 1'b1);
        check("flash_on unpowered", {7'h00, flash_on}, 8'h00);
        check("current_cap low level", {7'h00, current_cap}, 8'h00);
        wr(dev, 8'h00, '{8'hC0}, 1'b1);
        check("flash_on powered", {7'h00, flash_on}, 8'h01);
        // Timer expiry and a status event in the same cycle
        @(posedge clock);
        #1 flash_timer_done = 1'b1;
        status_event = 8'h20;
        @(posedge clock);
        #1 flash_timer_done = 1'b0;
        status_event = 8'h00;
        repeat (3) @(posedge clock);
        #1 check("cmd after expiry", cmd_reg, 8'h80);
        check("flash_on after expiry", {7'h00, flash_on}, 8'h00);
        check("attention pin", {6'h00, attention_out, attention_oe}, 8'h01);
        check("sda drive level", {7'h00, sda_out}, 8'h00);
        repeat (200) @(posedge clock);
        #1 check("attention held", {7'h00, attention_oe}, 8'h01);
        // Read dim, aux, status with master acks, last one unanswered
        rdn(8'h01, 3);
        check("read dim", rd[0], 8'h07);
        check("read aux", rd[1], 8'hA5);
        check("read status", rd[2], 8'h21);
        check("attention released", {7'h00, attention_oe}, 8'h00);
        // Status is read only, and an unmapped register reads as zero
        wr(dev, 8'h03, '{8'hFF}, 1'b1);
        check("status write ignored", {7'h00, attention_oe}, 8'h00);
        rdn(8'h03, 2);
        check("status cleared", rd[0], 8'h00);
        check("unmapped read", rd[1], 8'h00);
        results();
    end
endmodule
